// *** scan_alarm_pkg.sv ***
// Shared types and constants for the channel scaling and alarm block.
package scan_alarm_pkg;
    localparam int CHAN_COUNT = 8;
    localparam int VAL_W = 16;
    localparam int IDX_W = 3;
    localparam int FRAC_W = 12;
    localparam int UNIT_CHARS = 3;
    localparam logic [VAL_W-1:0] MIN_DEADBAND = 16'h0002;
    localparam logic [4:0] CHAR_DASH = 5'h00;
    localparam logic [4:0] CHAR_A = 5'h01;
    localparam logic [4:0] CHAR_Y = 5'h14;
    localparam logic [4:0] CHAR_C = 5'h03;
    localparam logic [4:0] CHAR_F = 5'h06;
    localparam logic [4:0] CHAR_DOT = 5'h1F;
    localparam logic [IDX_W-1:0] FIRST_CHAN = 3'h0;
    localparam int BLINK_BIT = 22;

    // Input kinds of a channel.
    typedef enum logic [1:0] {KIND_CURRENT, KIND_VOLTAGE, KIND_THERMO, KIND_OTHER_TEMP} input_kind_type;

    // Steps of the per-channel setup walk.
    typedef enum logic [3:0] {
        ST_MODE_SELECT, ST_LOW_SCALE, ST_OFFSET, ST_TARE, ST_SETPOINT,
        ST_LIMIT, ST_DEADBAND, ST_POLARITY, ST_UNIT
    } setup_step_type;

    // One channel's stored configuration.
    typedef struct packed {
        logic signed [VAL_W-1:0] low_scale;
        logic signed [VAL_W-1:0] high_scale;
        logic signed [VAL_W-1:0] offset;
        logic signed [VAL_W-1:0] tare;
        logic signed [VAL_W-1:0] setpoint;
        logic signed [VAL_W-1:0] limit;
        logic [VAL_W-1:0] deadband;
        logic normally_closed;
        logic enabled;
    } chan_cfg_type;

    // Write request from the keypad handler.
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] chan;
        chan_cfg_type cfg;
    } cfg_write_type;

    // Key events from the front panel, one-cycle pulses.
    typedef struct packed {
        logic confirm;
        logic step;
        logic next_digit;
        logic step_down;
        logic [IDX_W-1:0] chan;
        input_kind_type kind;
        logic kind_write;
        logic [1:0] char_pos;
        logic relay_reset;
    } key_event_type;
endpackage

// *** scan_alarm.sv ***
// Channel scaling, alarm relays, unit labels and setup sequencing.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Minimum input shows the low scale value.
// - Offset subtracted from raw input first.
// - Offset units follow current or voltage kind.
// - Tare subtracted from every scaled reading.
// - Deviation mode shows reading minus setpoint.
// - Universal first relay follows any alarm.
// - Own-channel first relay follows channel one.
// - Output activates when reading exceeds limit.
// - Release at or below limit minus deadband.
// - Deadband never below two.
// - Normally open closes contact when active.
// - Normally closed opens contact when active.
// - Three-character unit label per channel.
// - Letters step A to Y, below A dash.
// - Unprogrammed label shows three dots.
// - Changing input kind clears unit label.
// - Thermocouple loads C or F, still editable.
// - Temperature units toggle on step key.
// - Editable digit flashes.
// - Confirm walks setup steps then mode select.
// - Latched output holds until manual reset.
// - Disabled channels skipped, no error.
module scan_alarm
    import scan_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [VAL_W-1:0] raw_in,
    input wire logic [IDX_W-1:0] raw_chan,
    input wire logic raw_valid,
    input wire logic [VAL_W-1:0] full_span,
    input wire logic deviation_mode,
    input wire logic latched_mode,
    input wire logic first_relay_any_alarm,
    input wire cfg_write_type cfg_wr,
    input wire key_event_type keys,
    output logic signed [VAL_W-1:0] disp_value,
    output logic [IDX_W-1:0] disp_chan,
    output logic disp_valid,
    output logic [3*5-1:0] disp_units,
    output logic [CHAN_COUNT-1:0] relay_closed,
    output logic [CHAN_COUNT-1:0] alarm_active,
    output setup_step_type setup_step,
    output logic [1:0] edit_digit,
    output logic digit_blank,
    output logic offset_in_ma,
    output logic use_fahrenheit
);

    // Stored configuration per channel.
    chan_cfg_type cfg_r [CHAN_COUNT];
    // Input kind per channel, and Fahrenheit choice per channel.
    input_kind_type kind_r [CHAN_COUNT];
    logic [CHAN_COUNT-1:0] fahr_r;
    // Unit label characters per channel; programmed flag per channel.
    logic [4:0] unit_r [CHAN_COUNT][UNIT_CHARS];
    logic [CHAN_COUNT-1:0] unit_set_r;
    // Alarm state per channel.
    logic [CHAN_COUNT-1:0] alarm_r;
    // Readings shown last for each channel, held for alarm evaluation.
    logic signed [VAL_W-1:0] reading_r [CHAN_COUNT];
    logic [CHAN_COUNT-1:0] reading_ok_r;
    // Setup walk, edit cursor and blink counter.
    setup_step_type step_r;
    logic [1:0] digit_r;
    logic [BLINK_BIT:0] blink_r;

    // Linear scale of an offset-corrected input over the full span.
    // The product is kept two bits wider than both operand widths combined, so a full-span input
    // times a full display range cannot wrap before the divide.
    function automatic logic signed [VAL_W-1:0] scale_value(
        input logic signed [VAL_W-1:0] corrected,
        input logic [VAL_W-1:0] span,
        input logic signed [VAL_W-1:0] lo,
        input logic signed [VAL_W-1:0] hi
    );
        logic signed [2*VAL_W+1:0] prod;
        logic signed [2*VAL_W+1:0] quot;
        prod = (2*VAL_W+2)'(corrected) * (2*VAL_W+2)'(hi - lo);
        quot = (span == '0) ? '0 : prod / $signed({{(VAL_W+2){1'b0}}, span});
        scale_value = VAL_W'(quot) + lo;
    endfunction

    // Effective deadband, held at the floor.
    function automatic logic [VAL_W-1:0] eff_band(input logic [VAL_W-1:0] db);
        eff_band = (db < MIN_DEADBAND) ? MIN_DEADBAND : db;
    endfunction

    // Pipeline: offset removal, scaling, tare and deviation.
    logic signed [VAL_W-1:0] corrected;
    logic signed [VAL_W-1:0] scaled;
    logic signed [VAL_W-1:0] shown;
    chan_cfg_type cur_cfg;
    always_comb begin
        cur_cfg = cfg_r[raw_chan];
        // Offset is entered in the channel's own signal units, mA or V.
        corrected = $signed(raw_in) - cur_cfg.offset;
        // Zero corrected input lands exactly on low scale.
        scaled = scale_value(corrected, full_span, cur_cfg.low_scale, cur_cfg.high_scale);
        shown = scaled - cur_cfg.tare;
    end

    // Display register: a disabled channel is dropped and raises no error.
    always_ff @(posedge clk) begin
        if (rst) begin
            disp_value <= '0;
            disp_chan <= '0;
            disp_valid <= 1'b0;
        end else if (ce) begin
            disp_valid <= raw_valid && cur_cfg.enabled;
            if (raw_valid && cur_cfg.enabled) begin
                disp_chan <= raw_chan;
                // Deviation mode shows process minus setpoint.
                disp_value <= deviation_mode ? shown - cur_cfg.setpoint : shown;
            end
        end
    end

    // Latest reading per channel for the alarm comparators.
    always_ff @(posedge clk) begin
        if (rst) begin
            reading_ok_r <= '0;
            for (int i = 0; i < CHAN_COUNT; i++) begin
                reading_r[i] <= '0;
            end
        end else if (ce && raw_valid) begin
            reading_r[raw_chan] <= shown;
            reading_ok_r[raw_chan] <= cur_cfg.enabled;
        end
    end

    // Configuration store; the deadband floor is applied on write.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < CHAN_COUNT; i++) begin
                cfg_r[i] <= '0;
                cfg_r[i].deadband <= MIN_DEADBAND;
            end
        end else if (ce && cfg_wr.valid) begin
            cfg_r[cfg_wr.chan] <= cfg_wr.cfg;
            cfg_r[cfg_wr.chan].deadband <= eff_band(cfg_wr.cfg.deadband);
        end
    end

    // Alarm with hysteresis; latched mode holds until a manual reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_r <= '0;
        end else if (ce) begin
            for (int i = 0; i < CHAN_COUNT; i++) begin
                if (!reading_ok_r[i]) begin
                    alarm_r[i] <= 1'b0;
                end else if (reading_r[i] > cfg_r[i].limit) begin
                    alarm_r[i] <= 1'b1;
                end else if (latched_mode) begin
                    // Set wins over a reset that lands while still over limit.
                    if (keys.relay_reset && keys.chan == IDX_W'(i)) begin
                        alarm_r[i] <= 1'b0;
                    end
                // The band is widened as a signed number so negative readings compare right.
                end else if (32'(reading_r[i]) <= 32'(cfg_r[i].limit)
                             - $signed(32'(eff_band(cfg_r[i].deadband)))) begin
                    alarm_r[i] <= 1'b0;
                end
            end
        end
    end

    // Relay contacts: polarity per channel; first relay may follow any alarm.
    // Contacts are combinational from the alarm flops, so they settle in the alarm cycle.
    logic [CHAN_COUNT-1:0] drive;
    always_comb begin
        drive = alarm_r;
        drive[FIRST_CHAN] = first_relay_any_alarm ? (|alarm_r) : alarm_r[FIRST_CHAN];
        for (int i = 0; i < CHAN_COUNT; i++) begin
            // Closed when active if normally open, the reverse otherwise.
            relay_closed[i] = cfg_r[i].normally_closed ? !drive[i] : drive[i];
        end
    end
    assign alarm_active = alarm_r;

    // Input kind, temperature units and unit labels.
    always_ff @(posedge clk) begin
        if (rst) begin
            fahr_r <= '0;
            unit_set_r <= '0;
            for (int i = 0; i < CHAN_COUNT; i++) begin
                kind_r[i] <= KIND_CURRENT;
                for (int j = 0; j < UNIT_CHARS; j++) begin
                    unit_r[i][j] <= CHAR_DASH;
                end
            end
        end else if (ce) begin
            if (keys.kind_write && keys.kind != kind_r[keys.chan]) begin
                kind_r[keys.chan] <= keys.kind;
                for (int j = 0; j < UNIT_CHARS; j++) begin
                    unit_r[keys.chan][j] <= CHAR_DASH;
                end
                unit_set_r[keys.chan] <= 1'b0;
                if (keys.kind == KIND_THERMO) begin
                    // Last position carries the temperature letter.
                    unit_r[keys.chan][UNIT_CHARS-1] <= fahr_r[keys.chan] ? CHAR_F : CHAR_C;
                    unit_set_r[keys.chan] <= 1'b1;
                end
            end else if (keys.step && step_r == ST_UNIT) begin
                unit_set_r[keys.chan] <= 1'b1;
                if (keys.step_down) begin
                    // Below A gives the blanking dash; dash stays dash.
                    unit_r[keys.chan][keys.char_pos] <=
                        (unit_r[keys.chan][keys.char_pos] <= CHAR_A) ? CHAR_DASH
                        : unit_r[keys.chan][keys.char_pos] - 5'h01;
                end else begin
                    unit_r[keys.chan][keys.char_pos] <=
                        (unit_r[keys.chan][keys.char_pos] >= CHAR_Y) ? CHAR_Y
                        : unit_r[keys.chan][keys.char_pos] + 5'h01;
                end
            end else if (keys.step && step_r == ST_MODE_SELECT
                         && kind_r[keys.chan] >= KIND_THERMO) begin
                fahr_r[keys.chan] <= !fahr_r[keys.chan];
            end
        end
    end

    // Unit field of the displayed channel, dots when unprogrammed.
    always_comb begin
        for (int j = 0; j < UNIT_CHARS; j++) begin
            disp_units[j*5 +: 5] = unit_set_r[disp_chan] ? unit_r[disp_chan][j] : CHAR_DOT;
        end
    end
    assign offset_in_ma = (kind_r[disp_chan] == KIND_CURRENT);
    assign use_fahrenheit = fahr_r[disp_chan];

    // Setup walk on each confirm key press.
    always_ff @(posedge clk) begin
        if (rst) begin
            step_r <= ST_MODE_SELECT;
        end else if (ce && keys.confirm) begin
            case (step_r)
                ST_MODE_SELECT: step_r <= ST_LOW_SCALE;
                ST_LOW_SCALE: step_r <= ST_OFFSET;
                ST_OFFSET: step_r <= ST_TARE;
                ST_TARE: step_r <= ST_SETPOINT;
                ST_SETPOINT: step_r <= ST_LIMIT;
                ST_LIMIT: step_r <= ST_DEADBAND;
                ST_DEADBAND: step_r <= ST_POLARITY;
                ST_POLARITY: step_r <= ST_UNIT;
                default: step_r <= ST_MODE_SELECT;
            endcase
        end
    end
    assign setup_step = step_r;

    // Active digit cursor and flash; the cursor restarts on each new step.
    // The flash counter runs freely and only its top bit is seen, so the phase of
    // the flash at the entry of a step is arbitrary.
    always_ff @(posedge clk) begin
        if (rst) begin
            digit_r <= '0;
            blink_r <= '0;
        end else if (ce) begin
            blink_r <= blink_r + 1'b1;
            if (keys.confirm) begin
                digit_r <= '0;
            end else if (keys.next_digit) begin
                digit_r <= digit_r + 2'h1;
            end
        end
    end
    assign edit_digit = digit_r;
    assign digit_blank = (step_r != ST_MODE_SELECT) && blink_r[BLINK_BIT];

    // Output rises in the cycle after an over-limit reading is held.
    AST_OVER_LIMIT: assert property (@(posedge clk) disable iff (rst)
        (ce && reading_ok_r[1] && reading_r[1] > cfg_r[1].limit) |=> alarm_r[1])
        else $error("alarm not raised over limit");
    AST_DEADBAND_FLOOR: assert property (@(posedge clk) disable iff (rst)
        cfg_r[2].deadband >= MIN_DEADBAND)
        else $error("deadband below floor");
    AST_HOLD_IN_BAND: assert property (@(posedge clk) disable iff (rst)
        (ce && !latched_mode && alarm_r[1] && reading_ok_r[1]
         && 32'(reading_r[1]) > 32'(cfg_r[1].limit) - $signed(32'(cfg_r[1].deadband)))
        |=> alarm_r[1])
        else $error("alarm dropped inside deadband");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
        (ce && latched_mode && alarm_r[1] && reading_ok_r[1] && !keys.relay_reset) |=> alarm_r[1])
        else $error("latched alarm released");
    AST_UNIVERSAL: assert property (@(posedge clk) disable iff (rst)
        (first_relay_any_alarm && |alarm_r) |-> (relay_closed[0] != cfg_r[0].normally_closed))
        else $error("universal relay idle during alarm");
    AST_OWN_CHAN: assert property (@(posedge clk) disable iff (rst)
        (!first_relay_any_alarm) |-> (relay_closed[0] == (alarm_r[0] ^ cfg_r[0].normally_closed)))
        else $error("first relay not following channel one");
    AST_POLARITY: assert property (@(posedge clk) disable iff (rst)
        relay_closed[2] == (alarm_r[2] ^ cfg_r[2].normally_closed))
        else $error("relay polarity wrong");
    AST_SKIP_OFF: assert property (@(posedge clk) disable iff (rst)
        (ce && raw_valid && !cfg_r[raw_chan].enabled) |=> !disp_valid)
        else $error("disabled channel displayed");
    AST_WALK_BACK: assert property (@(posedge clk) disable iff (rst)
        (ce && keys.confirm && step_r == ST_UNIT) |=> step_r == ST_MODE_SELECT)
        else $error("setup did not return to mode select");
    AST_KIND_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (ce && keys.kind_write && keys.kind != KIND_THERMO && keys.kind != kind_r[keys.chan])
        |=> !unit_set_r[$past(keys.chan)])
        else $error("unit label kept after kind change");
    // A thermocouple selection leaves a programmed label behind.
    AST_THERMO_LOAD: assert property (@(posedge clk) disable iff (rst)
        (ce && keys.kind_write && keys.kind == KIND_THERMO && keys.kind != kind_r[keys.chan])
        |=> unit_set_r[$past(keys.chan)])
        else $error("thermocouple letter not loaded");
    // Stepping never leaves the letter range.
    AST_STEP_CEIL: assert property (@(posedge clk) disable iff (rst)
        unit_r[1][0] <= CHAR_Y)
        else $error("unit letter above top letter");
    AST_UNIT_DOTS: assert property (@(posedge clk) disable iff (rst)
        !unit_set_r[disp_chan] |-> disp_units == {UNIT_CHARS{CHAR_DOT}})
        else $error("unprogrammed label not shown as dots");
    // The step key in mode select flips the temperature units of a temperature channel.
    AST_TEMP_TOGGLE: assert property (@(posedge clk) disable iff (rst)
        (ce && keys.step && !keys.kind_write && step_r == ST_MODE_SELECT
         && kind_r[keys.chan] >= KIND_THERMO)
        |=> fahr_r[$past(keys.chan)] != $past(fahr_r[keys.chan]))
        else $error("temperature units not toggled");
    AST_DIGIT_RESTART: assert property (@(posedge clk) disable iff (rst)
        (ce && keys.confirm) |=> edit_digit == '0)
        else $error("digit cursor not restarted");
    AST_BLANK_IDLE: assert property (@(posedge clk) disable iff (rst)
        (step_r == ST_MODE_SELECT) |-> !digit_blank)
        else $error("digit flashing outside setup");
    AST_LATCH_RESET: assert property (@(posedge clk) disable iff (rst)
        (ce && latched_mode && reading_ok_r[1] && reading_r[1] <= cfg_r[1].limit
         && keys.relay_reset && keys.chan == 3'h1) |=> !alarm_r[1])
        else $error("latched alarm not reset");
    // A reading at or below limit minus band drops a non-latched alarm.
    AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
        (ce && !latched_mode && reading_ok_r[1]
         && 32'(reading_r[1]) <= 32'(cfg_r[1].limit) - $signed(32'(cfg_r[1].deadband)))
        |=> !alarm_r[1])
        else $error("alarm held below deadband");
endmodule
`default_nettype wire

// *** keypad_model.sv ***
// Front-panel operator model that drives key events and channel setup writes.
`timescale 1ns/1ps
`default_nettype none
module keypad_model
    import scan_alarm_pkg::*;
(
    input wire logic clk,
    output var key_event_type keys,
    output var cfg_write_type cfg_wr
);
    // Both buses idle at time zero so the block never sees an unknown strobe.
    initial begin
        keys = '0;
        cfg_wr = '0;
    end

    // One key event lasts one clock; launched and withdrawn on falling edges.
    // Each confirm press advances the setup walk by one step.
    task automatic send_keys(input key_event_type k);
        @(negedge clk) keys = k;
        @(negedge clk) keys = '0;
    endtask

    // Stores a whole channel configuration in one write pulse.
    task automatic write_cfg(input logic [IDX_W-1:0] ch, input chan_cfg_type c);
        @(negedge clk) begin
            cfg_wr.valid = 1'b1;
            cfg_wr.chan = ch;
            cfg_wr.cfg = c;
        end
        @(negedge clk) cfg_wr = '0;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the channel scaling and alarm block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(16'(g), 16'(e))
module testbench;
    import scan_alarm_pkg::*;
    logic clk = 1'b0; // Free-running 125 MHz clock.
    logic rst = 1'b1; // Held for the first 20 cycles.
    logic ce = 1'b1;
    logic [VAL_W-1:0] raw_in = '0;
    logic [IDX_W-1:0] raw_chan = '0;
    logic raw_valid = 1'b0;
    logic [VAL_W-1:0] full_span = 16'h0064; // Span of 100 keeps scaling exact.
    logic deviation_mode = 1'b0;
    logic latched_mode = 1'b0;
    logic any_sel = 1'b1;
    cfg_write_type cfg_wr;
    key_event_type keys;
    logic signed [VAL_W-1:0] disp_value;
    logic [IDX_W-1:0] disp_chan;
    logic disp_valid;
    logic [3*5-1:0] disp_units;
    logic [CHAN_COUNT-1:0] relay_closed;
    logic [CHAN_COUNT-1:0] alarm_active;
    setup_step_type setup_step;
    logic [1:0] edit_digit;
    logic digit_blank;
    logic offset_in_ma;
    logic use_fahrenheit;
    int checked = 0; // Comparisons made.
    int miscompares = 0; // Comparisons that failed.
    logic got_valid; // Display strobe seen one cycle after a reading.
    logic [VAL_W-1:0] got_value; // Display value seen with that strobe.
    key_event_type k;

    always #4 clk = ~clk;

    scan_alarm scan_alarm_inst (.clk(clk), .rst(rst), .ce(ce), .raw_in(raw_in),
        .raw_chan(raw_chan), .raw_valid(raw_valid), .full_span(full_span),
        .deviation_mode(deviation_mode), .latched_mode(latched_mode),
        .first_relay_any_alarm(any_sel), .cfg_wr(cfg_wr), .keys(keys),
        .disp_value(disp_value), .disp_chan(disp_chan), .disp_valid(disp_valid),
        .disp_units(disp_units), .relay_closed(relay_closed), .alarm_active(alarm_active),
        .setup_step(setup_step), .edit_digit(edit_digit), .digit_blank(digit_blank),
        .offset_in_ma(offset_in_ma), .use_fahrenheit(use_fahrenheit));

    keypad_model keypad_model_inst (.clk(clk), .keys(keys), .cfg_wr(cfg_wr));

    // Counts a comparison and reports a mismatch at once.
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single place where the run ends.
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Builds one channel configuration from plain numbers.
    function automatic chan_cfg_type mk(input int lo, input int hi, input int off,
        input int tare, input int sp, input int lim, input int db, input logic nc);
        chan_cfg_type c;
        c.low_scale = 16'(lo);
        c.high_scale = 16'(hi);
        c.offset = 16'(off);
        c.tare = 16'(tare);
        c.setpoint = 16'(sp);
        c.limit = 16'(lim);
        c.deadband = 16'(db);
        c.normally_closed = nc;
        c.enabled = 1'b1;
        return c;
    endfunction

    // Sends one reading; display is sampled after one edge, alarms after two.
    task automatic rd(input logic [IDX_W-1:0] ch, input int v);
        @(negedge clk) begin
            raw_chan = ch;
            raw_in = 16'(v);
            raw_valid = 1'b1;
        end
        @(negedge clk) raw_valid = 1'b0;
        got_valid = disp_valid;
        got_value = disp_value;
        @(negedge clk);
    endtask

    // Watchdog: a hang counts as a mismatch and goes to the verdict.
    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        `CHK(relay_closed, 0);
        `CHK(setup_step, ST_MODE_SELECT);
        `CHK(disp_units, {3{CHAR_DOT}});
        // Scaling with offset 5, tare 3, span 10..110; deadband 0 must be raised to 2.
        keypad_model_inst.write_cfg(3'h1, mk(10, 110, 5, 3, 0, 50, 0, 1'b0));
        rd(3'h1, 5);
        `CHK(got_valid, 1);
        `CHK(got_value, 7);
        `CHK(disp_chan, 1);
        rd(3'h1, 45);
        `CHK(got_value, 47);
        // Threshold and hysteresis with no tare: reading is raw plus 5.
        keypad_model_inst.write_cfg(3'h1, mk(10, 110, 5, 0, 20, 50, 0, 1'b0));
        rd(3'h1, 45);
        `CHK(alarm_active[1], 0);
        rd(3'h1, 46);
        `CHK(alarm_active[1], 1);
        `CHK(relay_closed[1], 1);
        `CHK(relay_closed[0], 1);
        any_sel = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(relay_closed[0], 0);
        any_sel = 1'b1;
        rd(3'h1, 44);
        `CHK(alarm_active[1], 1);
        rd(3'h1, 43);
        `CHK(alarm_active[1], 0);
        `CHK(relay_closed[1], 0);
        // Normally closed contact opens while in alarm.
        keypad_model_inst.write_cfg(3'h2, mk(10, 110, 5, 0, 0, 50, 2, 1'b1));
        @(negedge clk);
        `CHK(relay_closed[2], 1);
        rd(3'h2, 46);
        `CHK(relay_closed[2], 0);
        // Latched alarm survives a drop and clears only on a manual reset.
        latched_mode = 1'b1;
        rd(3'h1, 46);
        rd(3'h1, 20);
        `CHK(alarm_active[1], 1);
        k = '0;
        k.chan = 3'h1;
        k.relay_reset = 1'b1;
        keypad_model_inst.send_keys(k);
        @(negedge clk);
        `CHK(alarm_active[1], 0);
        latched_mode = 1'b0;
        // A channel never enabled gives no display strobe.
        rd(3'h3, 46);
        `CHK(got_valid, 0);
        // Deviation display: reading 60 against setpoint 20.
        deviation_mode = 1'b1;
        rd(3'h1, 55);
        `CHK(got_value, 40);
        deviation_mode = 1'b0;
        // Confirm walks every setup step and returns to mode select.
        k = '0;
        k.confirm = 1'b1;
        for (int i = 1; i <= 9; i++) begin
            keypad_model_inst.send_keys(k);
            `CHK(setup_step, setup_step_type'(i % 9));
        end
        // Kind changes: offset units, label clearing and temperature letter.
        k = '0;
        k.chan = 3'h1;
        k.kind_write = 1'b1;
        k.kind = KIND_CURRENT;
        keypad_model_inst.send_keys(k);
        rd(3'h1, 5);
        `CHK(offset_in_ma, 1);
        k.kind = KIND_VOLTAGE;
        keypad_model_inst.send_keys(k);
        rd(3'h1, 5);
        `CHK(offset_in_ma, 0);
        `CHK(disp_units, {3{CHAR_DOT}});
        k.kind = KIND_THERMO;
        keypad_model_inst.send_keys(k);
        rd(3'h1, 5);
        `CHK(use_fahrenheit, 0);
        `CHK(disp_units, {CHAR_C, CHAR_DASH, CHAR_DASH});
        // Step key in mode select flips the temperature units.
        k = '0;
        k.chan = 3'h1;
        k.step = 1'b1;
        keypad_model_inst.send_keys(k);
        rd(3'h1, 5);
        `CHK(use_fahrenheit, 1);
        // Walk to the unit step and edit the first letter.
        k = '0;
        k.confirm = 1'b1;
        repeat (8) keypad_model_inst.send_keys(k);
        `CHK(setup_step, ST_UNIT);
        k = '0;
        k.chan = 3'h1;
        k.step = 1'b1;
        keypad_model_inst.send_keys(k);
        `CHK(disp_units, {CHAR_C, CHAR_DASH, CHAR_A});
        k.step_down = 1'b1;
        repeat (2) keypad_model_inst.send_keys(k);
        `CHK(disp_units, {CHAR_C, CHAR_DASH, CHAR_DASH});
        k.step_down = 1'b0;
        repeat (21) keypad_model_inst.send_keys(k);
        `CHK(disp_units[4:0], CHAR_Y);
        // Cursor moves on next digit and restarts on confirm.
        k = '0;
        k.next_digit = 1'b1;
        repeat (2) keypad_model_inst.send_keys(k);
        `CHK(edit_digit, 2);
        k = '0;
        k.confirm = 1'b1;
        keypad_model_inst.send_keys(k);
        `CHK(edit_digit, 0);
        `CHK(setup_step, ST_MODE_SELECT);
        `CHK(digit_blank, 0);
        // A kind change wipes the programmed label back to dots.
        k = '0;
        k.chan = 3'h1;
        k.kind_write = 1'b1;
        k.kind = KIND_VOLTAGE;
        keypad_model_inst.send_keys(k);
        `CHK(disp_units, {3{CHAR_DOT}});
        give_verdict();
    end
endmodule
`default_nettype wire
